// ==== src/cgts_pkg.sv ====
// Purpose: shared constants for the clock generator trim and status block
// Assumes: Avalon-MM slave, 32-bit data, word-aligned registers
// Notes: offsets are byte addresses
package cgts_pkg;
    // ==========================================================
    // Register map
    // ==========================================================
    localparam logic [3:0] CGTS_OFF_COARSE = 4'h0; // Coarse period adjust
    localparam logic [3:0] CGTS_OFF_STATUS = 4'h4; // Status and control
    localparam logic [3:0] CGTS_OFF_CTRL = 4'h8; // Lost-lock interrupt enable control
    localparam logic [3:0] CGTS_OFF_MODE = 4'hc; // Clock mode inputs view
    localparam int CGTS_ADDR_W = 4; // Byte address width
    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [7:0] CGTS_COARSE_RST = 8'h80; // Mid-scale coarse adjust
    localparam logic CGTS_FINE_RST = 1'b0; // Fine adjust after reset
    localparam logic CGTS_LOST_LOCK_IRQ_ENABLE_RST = 1'b0; // Interrupt enable after reset
    // ==========================================================
    // Status field positions
    // ==========================================================
    localparam int CGTS_BIT_LOST_LOCK_STICKY_FLAG = 7; // Sticky lost-lock flag
    localparam int CGTS_BIT_LOCK = 6; // Live lock flag
    localparam int CGTS_BIT_LOOP = 5; // Loop in use status
    localparam int CGTS_BIT_REF = 4; // Reference status
    localparam int CGTS_BIT_OUT_LO = 2; // Output source status low bit
    localparam int CGTS_BIT_OSCI = 1; // Crystal startup done
    localparam int CGTS_BIT_FINE = 0; // Fine period adjust
    localparam int CGTS_BIT_LOST_LOCK_IRQ_ENABLE = 7; // Irq enable in control register
    // ==========================================================
    // Output source encodings
    // ==========================================================
    localparam logic [1:0] CGTS_SRC_FLL = 2'h0; // FLL output
    localparam logic [1:0] CGTS_SRC_INT = 2'h1; // Internal reference
    localparam logic [1:0] CGTS_SRC_EXT = 2'h2; // External reference
    localparam logic [1:0] CGTS_SRC_PLL = 2'h3; // PLL output
    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CGTS_CLK_MHZ = 250; // Bus clock rate
    localparam int CGTS_SYNC_STAGES = 2; // Synchroniser depth
    localparam int CGTS_OSC_INIT_NS = 4000; // Crystal startup time in ns
    localparam int CGTS_OSC_INIT_CYC = (CGTS_OSC_INIT_NS * CGTS_CLK_MHZ + 999) / 1000;
endpackage

// ==== src/cgts_sync.sv ====
// Purpose: multi-bit level synchroniser into the bus clock domain
// Assumes: each bit is a slowly changing level
// Notes: first stage is read only by the second stage
`timescale 1ns/10ps
module cgts_sync #(
    parameter int WIDTH = 4
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q; // First capture stage

    // ==========================================================
    // Two-stage capture, one per bit
    // ==========================================================
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            always_ff @(posedge clk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    meta_q[gi] <= 1'b0;
                    sync_out[gi] <= 1'b0;
                end else begin
                    meta_q[gi] <= async_in[gi];
                    sync_out[gi] <= meta_q[gi];
                end
            end
        end
    endgenerate
endmodule

// ==== src/cgts_top.sv ====
// Purpose: trim and status/control registers of the clock generator
// Assumes: Avalon-MM slave on clk_in; loop status arrives from other domains
// Notes: analogue loops and mode machine sit outside this block
`timescale 1ns/10ps
module cgts_top
    import cgts_pkg::*;
#(
    parameter int OSC_INIT_CYC = cgts_pkg::CGTS_OSC_INIT_CYC
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    // Avalon-MM slave
    input wire logic [cgts_pkg::CGTS_ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    output logic [1:0] avs_response_out,
    // Control state from the mode-control registers
    input wire logic ref_source_select_in,
    input wire logic loop_select_in,
    input wire logic [2:0] ref_divider_in,
    input wire logic [3:0] vco_multiplier_in,
    input wire logic ext_ref_kind_select_in,
    input wire logic ext_ref_clock_enable_in,
    input wire logic fll_enabled_in,
    input wire logic pll_enabled_in,
    input wire logic stop_entry_in,
    input wire logic fll_int_ref_mode_in,
    input wire logic fll_bypass_int_mode_in,
    input wire logic bypass_lowpower_int_mode_in,
    input wire logic bypass_lowpower_ext_mode_in,
    input wire logic ext_ref_mode_in,
    input wire logic pll_ext_mode_in,
    // Asynchronous loop status from the clock domains
    input wire logic loop_locked_async_in,
    input wire logic loop_in_use_async_in,
    input wire logic ref_in_use_async_in,
    input wire logic [1:0] out_source_async_in,
    input wire logic osc_running_async_in,
    // Trim outputs, crystal request and interrupt
    output logic [7:0] coarse_period_adjust_out,
    output logic fine_period_adjust_out,
    output logic osc_request_out,
    output logic lost_lock_irq_out
);
    import cgts_pkg::*;

    // ==========================================================
    // Declarations
    // ==========================================================
    logic [7:0] coarse_q; // Coarse period adjust
    logic fine_q; // Fine period adjust
    logic lost_lock_irq_enable_q; // Lost-lock interrupt enable
    logic lost_lock_sticky_flag_q; // Sticky lost-lock flag
    logic lock_q; // Lock flag as reported
    logic was_locked_q; // Lock acquired since last qualify
    logic lock_hold_q; // Lock forced clear until loop unlocks
    logic osci_q; // Crystal startup done
    logic [15:0] osc_cnt_q; // Init cycle counter
    logic [5:0] sync_w; // Synchronised status bits
    logic osc_live; // Crystal reports running, synchronised
    logic [1:0] sel_prev_q; // Previous reference and loop selects
    logic [2:0] div_prev_q; // Previous reference divider
    logic [3:0] vco_prev_q; // Previous multiplier
    logic stop_prev_q; // Previous stop level
    logic blp_prev_q; // Previous low-power bypass level
    logic [31:0] rdata_q; // Read data register
    logic wait_q; // Waitrequest register
    logic [1:0] resp_q; // Response register
    logic irq_q; // Interrupt register
    logic osc_req_q; // Oscillator request register
    logic wr_acc; // Write accepted this cycle
    logic rd_acc; // Read accepted this cycle
    logic lock_det_en; // Lock detection active
    logic lock_kill; // Event that clears lock
    logic coarse_wr; // Coarse register write
    logic ext_in_use; // External reference in use
    logic osc_drop; // Startup flag clear condition

    // Byte-lane zero write check
    function automatic logic cgts_hit(input logic [3:0] addr, input logic [3:0] off,
                                      input logic [3:0] be);
        cgts_hit = (addr == off) && be[0];
    endfunction

    // ==========================================================
    // Synchronisers for status from other domains
    // ==========================================================
    // Bit 5 running, 4 locked, 3 loop in use, 2 reference in use, 1:0 source
    // Status bits never bypass the two flops, so software sees settled values
    cgts_sync #(
        .WIDTH(6)
    ) u_sync (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .async_in({osc_running_async_in, loop_locked_async_in, loop_in_use_async_in,
                   ref_in_use_async_in, out_source_async_in}),
        .sync_out(sync_w)
    );
    assign osc_live = sync_w[5];

    // ==========================================================
    // Bus handshake
    // ==========================================================
    // One wait cycle, then the access completes
    // A request seen with waitrequest high is answered at the next edge
    assign wr_acc = avs_write_in && !wait_q;
    assign rd_acc = avs_read_in && !wait_q;
    assign coarse_wr = wr_acc && cgts_hit(avs_address_in, CGTS_OFF_COARSE, avs_byteenable_in);

    // Waitrequest high by default, low for one cycle per access
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wait_q <= 1'b1;
        end else if ((avs_read_in || avs_write_in) && wait_q) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= 1'b1;
        end
    end

    // Read data and response; unmapped returns decode error
    // Captured in the wait cycle, they stand for the one answer cycle
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_q <= 32'h0000_0000;
            resp_q <= 2'h0;
        end else if ((avs_read_in || avs_write_in) && wait_q) begin
            rdata_q <= 32'h0000_0000;
            resp_q <= 2'h0;
            unique case (avs_address_in)
                CGTS_OFF_COARSE: begin
                    rdata_q[7:0] <= coarse_q;
                end
                CGTS_OFF_STATUS: begin
                    rdata_q[7:0] <= {lost_lock_sticky_flag_q, lock_q, sync_w[3], sync_w[2], sync_w[1:0],
                                     osci_q, fine_q};
                end
                CGTS_OFF_CTRL: begin
                    rdata_q[CGTS_BIT_LOST_LOCK_IRQ_ENABLE] <= lost_lock_irq_enable_q;
                end
                CGTS_OFF_MODE: begin
                    rdata_q[3:0] <= {ext_in_use, lock_det_en, stop_entry_in, osc_req_q};
                end
                default: begin
                    resp_q <= 2'h3;
                end
            endcase
        end
    end

    // ==========================================================
    // Trim and interrupt enable registers
    // ==========================================================
    // Coarse value drives period directly; higher lengthens it
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            coarse_q <= CGTS_COARSE_RST;
        end else if (coarse_wr) begin
            coarse_q <= avs_writedata_in[7:0];
        end
    end

    // Fine bit is the only writable status bit besides the sticky flag
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            fine_q <= CGTS_FINE_RST;
        end else if (wr_acc && cgts_hit(avs_address_in, CGTS_OFF_STATUS, avs_byteenable_in)) begin
            fine_q <= avs_writedata_in[CGTS_BIT_FINE];
        end
    end

    // Interrupt enable
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            lost_lock_irq_enable_q <= CGTS_LOST_LOCK_IRQ_ENABLE_RST;
        end else if (wr_acc && cgts_hit(avs_address_in, CGTS_OFF_CTRL, avs_byteenable_in)) begin
            lost_lock_irq_enable_q <= avs_writedata_in[CGTS_BIT_LOST_LOCK_IRQ_ENABLE];
        end
    end

    // ==========================================================
    // Lock tracking
    // ==========================================================
    assign lock_det_en = fll_enabled_in || pll_enabled_in;

    // Previous values for change detection
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sel_prev_q <= 2'h0;
            div_prev_q <= 3'h0;
            vco_prev_q <= 4'h0;
            stop_prev_q <= 1'b0;
            blp_prev_q <= 1'b0;
        end else begin
            sel_prev_q <= {ref_source_select_in, loop_select_in};
            div_prev_q <= ref_divider_in;
            vco_prev_q <= vco_multiplier_in;
            stop_prev_q <= stop_entry_in;
            blp_prev_q <= bypass_lowpower_int_mode_in || bypass_lowpower_ext_mode_in;
        end
    end

    // Events that force the lock flag clear; the select copies reset to
    // zero, so one kill may follow reset and its hold ends once unlocked
    assign lock_kill =
        (sel_prev_q != {ref_source_select_in, loop_select_in}) ||
        (div_prev_q != ref_divider_in) ||
        (coarse_wr && (avs_writedata_in[7:0] != coarse_q) &&
         (fll_int_ref_mode_in || fll_bypass_int_mode_in)) ||
        ((vco_prev_q != vco_multiplier_in) && pll_ext_mode_in) ||
        (stop_entry_in && !stop_prev_q) ||
        ((bypass_lowpower_int_mode_in || bypass_lowpower_ext_mode_in) && !blp_prev_q);

    // Hold lock clear after a kill until the loop reports unlocked
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            lock_hold_q <= 1'b0;
        end else if (lock_kill) begin
            lock_hold_q <= 1'b1;
        end else if (!sync_w[4]) begin
            lock_hold_q <= 1'b0;
        end
    end

    // Reported lock flag
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            lock_q <= 1'b0;
        end else begin
            lock_q <= lock_det_en && sync_w[4] && !lock_kill && !lock_hold_q;
        end
    end

    // Remember that lock was acquired; a drop of the loop disarms it, so
    // one loss sets the sticky flag once and a later clear by software holds
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            was_locked_q <= 1'b0;
        end else if (!lock_det_en || !sync_w[4]) begin
            was_locked_q <= 1'b0;
        end else if (lock_q) begin
            was_locked_q <= 1'b1;
        end else if (lock_kill || lock_hold_q) begin
            was_locked_q <= 1'b0;
        end
    end

    // Sticky flag; hardware set wins over software clear
    // Writing zero, or one while the flag is clear, leaves it as it is
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            lost_lock_sticky_flag_q <= 1'b0;
        end else if (lock_det_en && was_locked_q && !sync_w[4] && !lock_hold_q) begin
            lost_lock_sticky_flag_q <= 1'b1;
        end else if (wr_acc && cgts_hit(avs_address_in, CGTS_OFF_STATUS, avs_byteenable_in)
                     && avs_writedata_in[CGTS_BIT_LOST_LOCK_STICKY_FLAG] && lost_lock_sticky_flag_q) begin
            lost_lock_sticky_flag_q <= 1'b0;
        end
    end

    // Interrupt request
    // Level follows the sticky flag and its enable one cycle late
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= lost_lock_sticky_flag_q && lost_lock_irq_enable_q;
        end
    end

    // ==========================================================
    // Crystal startup
    // ==========================================================
    // External reference counts as in use by its enable or by a mode
    assign ext_in_use = ext_ref_clock_enable_in || ext_ref_mode_in;
    assign osc_drop = !ext_ref_kind_select_in ||
        ((fll_int_ref_mode_in || fll_bypass_int_mode_in || bypass_lowpower_int_mode_in) &&
         !ext_ref_clock_enable_in);

    // Crystal requested when kind select is one and the external reference is in use
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            osc_req_q <= 1'b0;
        end else begin
            osc_req_q <= ext_ref_kind_select_in && ext_in_use;
        end
    end

    // Count init cycles while the crystal reports running, then set the
    // done flag; the count is kept across a pause in the running report
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            osc_cnt_q <= 16'h0000;
            osci_q <= 1'b0;
        end else if (osc_drop) begin
            osc_cnt_q <= 16'h0000;
            osci_q <= 1'b0;
        end else if (osc_req_q && osc_live && !osci_q) begin
            if (osc_cnt_q == 16'(OSC_INIT_CYC - 1)) begin
                osci_q <= 1'b1;
            end else begin
                osc_cnt_q <= osc_cnt_q + 16'h0001;
            end
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    // Status fields come through the synchroniser only
    assign avs_readdata_out = rdata_q;
    assign avs_waitrequest_out = wait_q;
    assign avs_response_out = resp_q;
    assign coarse_period_adjust_out = coarse_q;
    assign fine_period_adjust_out = fine_q;
    assign osc_request_out = osc_req_q;
    assign lost_lock_irq_out = irq_q;
endmodule

// ==== sim/cgts_assertions.sv ====
// Purpose: port checks of the clock generator trim and status block
// Assumes: bound to cgts_top, one clock domain
// Notes: mapped offsets have the low two address bits clear
`timescale 1ns/10ps
module cgts_checker
    import cgts_pkg::*;
(
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic [cgts_pkg::CGTS_ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire logic [1:0] avs_response_out,
    input wire logic ext_ref_kind_select_in,
    input wire logic [7:0] coarse_period_adjust_out,
    input wire logic fine_period_adjust_out,
    input wire logic osc_request_out
);
    // ==========================================================
    // Helpers
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    logic wr_w; // Lane 0 write completes here
    logic map_w; // Address is mapped
    assign wr_w = !avs_waitrequest_out && avs_write_in && avs_byteenable_in[0];
    assign map_w = avs_address_in[1:0] == 2'h0;
    // ==========================================================
    // Bus handshake and answers
    wait_pulse_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest low for more than one cycle");
    req_answer_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
        |=> !avs_waitrequest_out) else $error("request not answered next cycle");
    bad_resp_a: assert property (!avs_waitrequest_out && !map_w |-> avs_response_out == 2'h3)
        else $error("unmapped access not flagged");
    good_resp_a: assert property (!avs_waitrequest_out && map_w |-> avs_response_out == 2'h0)
        else $error("mapped access flagged");
    upper_zero_a: assert property (!avs_waitrequest_out && avs_read_in
        |-> avs_readdata_out[31:8] == 24'h0) else $error("upper read bits set");
    // ==========================================================
    // Trim outputs and crystal request
    coarse_write_a: assert property (wr_w && avs_address_in == CGTS_OFF_COARSE
        |=> coarse_period_adjust_out == $past(avs_writedata_in[7:0]))
        else $error("coarse adjust not written");
    coarse_hold_a: assert property ($changed(coarse_period_adjust_out)
        |-> $past(wr_w && avs_address_in == CGTS_OFF_COARSE)) else $error("coarse moved");
    fine_write_a: assert property (wr_w && avs_address_in == CGTS_OFF_STATUS
        |=> fine_period_adjust_out == $past(avs_writedata_in[0])) else $error("fine not written");
    fine_hold_a: assert property ($changed(fine_period_adjust_out)
        |-> $past(wr_w && avs_address_in == CGTS_OFF_STATUS)) else $error("fine moved");
    osc_kind_a: assert property (!ext_ref_kind_select_in
        && $past(!ext_ref_kind_select_in) |-> !osc_request_out)
        else $error("crystal requested with clock kind");
endmodule

// ==== sim/cgts_top_bench.sv ====
// Purpose: self-checking bench of the trim and status block
// Assumes: status inputs settle within six cycles
// Notes: crystal startup shortened to eight cycles
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin err_total++; \
    $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module cgts_top_bench;
    import cgts_pkg::*;
    // ==========================================================
    // Stimulus state
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [3:0] ad = 4'h0, be = 4'h0, vco = 4'h1;
    logic rd = 1'b0, wr = 1'b0, rsel = 1'b1, lsel = 1'b0, kind = 1'b0, eren = 1'b0;
    logic fen = 1'b0, pen = 1'b0, stp = 1'b0, fim = 1'b0, fll_bypass_int_mode = 1'b0, bypass_lowpower_int_mode = 1'b0;
    logic bypass_lowpower_ext_mode = 1'b0, xm = 1'b0, pem = 1'b0, lck = 1'b0, lp = 1'b0, rf = 1'b0, orun = 1'b0;
    logic [2:0] ref_divider = 3'h0;
    logic [1:0] src = 2'h0, rsp;
    logic [31:0] wd = 32'h0, rdat, v;
    logic [31:0] rdo;
    logic wt_o, fine_o, oreq_o, irq_o, fine_v;
    logic [1:0] rsp_o;
    logic [7:0] crs_o, crs_v;
    int err_total = 0;
    int checks_done = 0;
    int seed = 49566;
    always #2 clk_in = ~clk_in;
    cgts_top #(.OSC_INIT_CYC(8)) cgts_top_inst (.clk_in(clk_in), .rstn_in(rstn_in),
        .avs_address_in(ad), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
        .avs_byteenable_in(be), .avs_readdata_out(rdo), .avs_waitrequest_out(wt_o),
        .avs_response_out(rsp_o), .ref_source_select_in(rsel), .loop_select_in(lsel),
        .ref_divider_in(ref_divider), .vco_multiplier_in(vco), .ext_ref_kind_select_in(kind),
        .ext_ref_clock_enable_in(eren), .fll_enabled_in(fen), .pll_enabled_in(pen),
        .stop_entry_in(stp), .fll_int_ref_mode_in(fim), .fll_bypass_int_mode_in(fll_bypass_int_mode),
        .bypass_lowpower_int_mode_in(bypass_lowpower_int_mode), .bypass_lowpower_ext_mode_in(bypass_lowpower_ext_mode),
        .ext_ref_mode_in(xm), .pll_ext_mode_in(pem), .loop_locked_async_in(lck),
        .loop_in_use_async_in(lp), .ref_in_use_async_in(rf), .out_source_async_in(src),
        .osc_running_async_in(orun), .coarse_period_adjust_out(crs_o),
        .fine_period_adjust_out(fine_o), .osc_request_out(oreq_o), .lost_lock_irq_out(irq_o));
    // ==========================================================
    // Bus cycle, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
        input logic [3:0] b);
        @(posedge clk_in);
        ad <= a;
        rd <= !w;
        wr <= w;
        wd <= d;
        be <= b;
        do begin
            @(posedge clk_in);
        end while (wt_o !== 1'b0);
        rdat = rdo;
        rsp = rsp_o;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    // Expected status byte
    function automatic logic [7:0] st_exp(logic ll, logic lk, logic p, logic r, logic [1:0] s,
        logic o);
        return {ll, lk, p, r, s, o, fine_v};
    endfunction
    task automatic st_chk(input logic [7:0] ex, input logic [7:0] m, input string nm);
        bus(1'b0, CGTS_OFF_STATUS, 32'h0, 4'hf);
        `CHK(nm, ex & m, rdat[7:0] & m)
    endtask
    // Lock-clearing events by kind
    task automatic kill(input int k);
        @(posedge clk_in);
        case (k)
            0: rsel <= !rsel;
            1: begin
                lsel <= !lsel;
                fen <= lsel;
                pen <= !lsel;
            end
            2: ref_divider <= ref_divider + 3'h1;
            3: stp <= 1'b1;
            4: bypass_lowpower_int_mode <= 1'b1;
            5: bypass_lowpower_ext_mode <= 1'b1;
            6: fim <= 1'b1;
            default: pem <= 1'b1;
        endcase
        crs_v = ~crs_v;
        if (k == 6) bus(1'b1, CGTS_OFF_COARSE, {24'h0, crs_v}, 4'h1);
        else crs_v = ~crs_v;
        if (k == 7) begin
            @(posedge clk_in);
            vco <= vco + 4'h1;
        end
    endtask
    task wrap_up;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        wt(30000);
        err_total++;
        wrap_up;
    end
    // ==========================================================
    // Main sequence
    initial begin
        wt(10);
        rstn_in <= 1'b1;
        bus(1'b0, CGTS_OFF_COARSE, 32'h0, 4'hf);
        `CHK("coarse reset", CGTS_COARSE_RST, rdat[7:0])
        bus(1'b0, CGTS_OFF_CTRL, 32'h0, 4'hf);
        `CHK("irq enable reset", CGTS_LOST_LOCK_IRQ_ENABLE_RST, rdat[7])
        crs_v = CGTS_COARSE_RST;
        for (int i = 0; i < 8; i++) begin
            v = $random(seed);
            if (i < 2) v[7:0] = {8{i[0]}};
            bus(1'b1, CGTS_OFF_COARSE, v, i < 2 ? 4'h1 : v[11:8]);
            if (i < 2 || v[8]) crs_v = v[7:0];
            bus(1'b0, CGTS_OFF_COARSE, 32'h0, 4'hf);
            `CHK("coarse read", crs_v, rdat[7:0])
            `CHK("coarse out", crs_v, crs_o)
        end
        bus(1'b1, 4'h1, 32'h55, 4'hf);
        `CHK("unmapped resp", 2'h3, rsp)
        `CHK("coarse kept", crs_v, crs_o)
        v = $random(seed);
        bus(1'b1, CGTS_OFF_STATUS, v, 4'h1);
        fine_v = v[0];
        st_chk(st_exp(0, 0, 0, 0, 2'h0, 0), 8'hff, "status ignored");
        `CHK("fine out", fine_v, fine_o)
        for (int i = 0; i < 8; i++) begin
            v = $random(seed);
            @(posedge clk_in);
            lp <= v[0];
            rf <= v[1];
            orun <= v[2];
            src <= i[1:0];
            wt(3);
            st_chk(st_exp(0, 0, v[0], v[1], i[1:0], 0), 8'h3c, "synced");
        end
        lck <= 1'b1;
        wt(6);
        st_chk(8'h00, 8'hc0, "no detection");
        fen <= 1'b1;
        wt(6);
        st_chk(8'h40, 8'hc0, "locked");
        lck <= 1'b0;
        wt(6);
        st_chk(8'h80, 8'hc0, "lost lock");
        `CHK("irq masked", 1'b0, irq_o)
        bus(1'b1, CGTS_OFF_CTRL, 32'h80, 4'h1);
        wt(3);
        `CHK("irq raised", 1'b1, irq_o)
        bus(1'b1, CGTS_OFF_STATUS, {31'h0, fine_v}, 4'h1);
        st_chk(8'h80, 8'h80, "write zero");
        bus(1'b1, CGTS_OFF_STATUS, {24'h0, 1'b1, 6'h0, fine_v}, 4'h1);
        wt(3);
        st_chk(8'h00, 8'h80, "write one");
        `CHK("irq cleared", 1'b0, irq_o)
        lck <= 1'b1;
        wt(6);
        for (int k = 0; k < 8; k++) begin
            st_chk(8'h40, 8'hc0, "relocked");
            kill(k);
            wt(6);
            st_chk(8'h00, 8'hc0, "lock killed");
            stp <= 1'b0;
            bypass_lowpower_int_mode <= 1'b0;
            bypass_lowpower_ext_mode <= 1'b0;
            fim <= 1'b0;
            pem <= 1'b0;
            lck <= 1'b0;
            wt(6);
            lck <= 1'b1;
            wt(6);
        end
        kind <= 1'b1;
        eren <= 1'b1;
        orun <= 1'b0;
        wt(12);
        st_chk(8'h00, 8'h02, "startup waits");
        orun <= 1'b1;
        wt(2);
        st_chk(8'h00, 8'h02, "startup early");
        `CHK("crystal request", 1'b1, oreq_o)
        wt(12);
        st_chk(8'h02, 8'h02, "startup done");
        eren <= 1'b0;
        fim <= 1'b1;
        wt(4);
        st_chk(8'h00, 8'h02, "startup int mode");
        fim <= 1'b0;
        xm <= 1'b1;
        wt(14);
        st_chk(8'h02, 8'h02, "startup ext mode");
        kind <= 1'b0;
        wt(4);
        st_chk(8'h00, 8'h02, "startup withdrawn");
        `CHK("no request", 1'b0, oreq_o)
        bus(1'b0, CGTS_OFF_MODE, 32'h0, 4'hf);
        `CHK("mode view", 4'hc, rdat[3:0])
        wrap_up;
    end
endmodule
bind cgts_top cgts_checker cgts_checker_inst (.clk_in(clk_in), .rstn_in(rstn_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .avs_response_out(avs_response_out), .ext_ref_kind_select_in(ext_ref_kind_select_in),
    .coarse_period_adjust_out(coarse_period_adjust_out),
    .fine_period_adjust_out(fine_period_adjust_out), .osc_request_out(osc_request_out));
